// file: bench/tsa_i2c_master.sv
// Serial bus master model: clock, open-drain data, register access
`timescale 1ns/10ps
module tsa_i2c_master #(
   parameter int Q = 12 // Quarter bit in clocks, keeps phases above 10
) (
   input wire logic clk, // Timing clock
   output logic scl, // Bus clock
   output logic sda, // Data drive, 1 releases to pull-up
   input wire logic sda_in // Resolved data wire
);
   logic [6:0] dev_addr = 7'h48; // Target address
   logic [7:0] q_x; // Unused byte
   logic a_x; // Unused level
   initial scl = 1'b1;
   initial sda = 1'b1;
   // Four bus quarters, levels MSB first; data sampled after the second
   task automatic seq(input logic [3:0] c, input logic [3:0] d, output logic r);
      for (int i = 3; i >= 0; i--) begin
         scl = c[i];
         sda = d[i];
         repeat (Q) @(negedge clk);
         if (i == 2) r = sda_in;
      end
   endtask
   // Byte out and in at once; mack 1 releases the ninth bit
   task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) seq(4'h6, {4{d[i]}}, q[i]);
      seq(4'h6, {4{mack}}, r);
      ack = !r;
   endtask
   // Address only, reports the acknowledge
   task automatic probe(output logic a);
      seq(4'h6, 4'hC, a_x); // Start
      xfer({dev_addr, 1'b0}, 1'b1, q_x, a);
      seq(4'h7, 4'h3, a_x); // Stop
   endtask
   // Pointer first, then n data bytes, MSB first
   task automatic wr(input logic [7:0] p, input int n = 0, input logic [15:0] v = 16'h0000);
      seq(4'h6, 4'hC, a_x);
      xfer({dev_addr, 1'b0}, 1'b1, q_x, a_x);
      xfer(p, 1'b1, q_x, a_x);
      if (n > 0) xfer(v[15:8], 1'b1, q_x, a_x);
      if (n > 1) xfer(v[7:0], 1'b1, q_x, a_x);
      seq(4'h7, 4'h3, a_x);
   endtask
   // Word read, NACK ends it
   task automatic rd(output logic [15:0] v);
      seq(4'h6, 4'hC, a_x);
      xfer({dev_addr, 1'b1}, 1'b1, q_x, a_x);
      xfer(8'hFF, 1'b0, v[15:8], a_x);
      xfer(8'hFF, 1'b1, v[7:0], a_x);
      seq(4'h7, 4'h3, a_x);
   endtask
endmodule

// file: bench/tsa_top_monitor.sv
// Port checks for the temperature monitor, bound to its top
`timescale 1ns/10ps
module tsa_top_monitor #(
   parameter int CONV_CYC = 200 // Cycles per conversion
) (
   input wire logic sys_clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic scl_i, // Bus clock level
   input wire logic sda_o, // Data drive value
   input wire logic sda_oe, // Data pull enable
   input wire logic alarm_out // Alarm pin
);
   int up_reg, up_next; // Cycles since release, saturating
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   // No conversion can end before one full period
   always_comb up_next = (up_reg < CONV_CYC) ? up_reg + 1 : up_reg;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) up_reg <= 0;
      else up_reg <= up_next;
   end
   AST_DRIVE_ZERO: assert property (!sda_o) else $error("data drive not zero");
   AST_OE_RESET: assert property ($rose(rstn) |-> !sda_oe [*8]) else $error("data pulled after reset");
   AST_ALARM_RESET: assert property ($rose(rstn) |-> alarm_out [*8]) else $error("alarm after reset");
   AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_i) else $error("data moved, clock high");
   AST_OE_HOLD_HIGH: assert property (scl_i [*8] |-> $stable(sda_oe)) else $error("data moved in high");
   AST_OE_LATE: assert property ($changed(sda_oe) |-> !$past(scl_i, 5)) else $error("data moved early");
   AST_OE_PROMPT: assert property ($changed(sda_oe) |-> $past(scl_i, 20)) else $error("data moved late");
   AST_ALARM_EARLY: assert property (up_reg < CONV_CYC |-> $stable(alarm_out)) else $error("early alarm");
endmodule
bind tsa_top tsa_top_monitor #(.CONV_CYC(CONV_CYC)) u_mon (.sys_clk(sys_clk), .rstn(rstn), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe(sda_oe), .alarm_out(alarm_out));

// file: bench/tsa_top_tb_top.sv
// Self-checking bench for the temperature monitor
`timescale 1ns/10ps
module tsa_top_tb_top;
   import tsa_pkg::*;
   localparam int CC = 2000; // Shortened conversion period
   logic sys_clk = 1'b0; // 125 MHz
   logic adc_clk = 1'b0; // Converter clock
   logic rstn = 1'b0; // Reset, active low
   logic adc_valid = 1'b0; // Result strobe
   logic [ADC_W-1:0] adc_result = 12'h000; // Result word
   logic [1:0] strap = 2'h0; // Address strap
   logic scl, sda_m, sda_o, sda_oe, alarm_out; // Bus and alarm
   logic [15:0] v; // Read word
   logic a; // Acknowledge seen
   wire logic sda_w = sda_m & ~sda_oe; // Pulled-up data wire
   wire logic [15:0] al_w = {15'h0, alarm_out}; // Alarm pin, widened
   int err_total = 0, checks_done = 0;
   always #4 sys_clk = ~sys_clk;
   initial #13 forever #32 adc_clk = ~adc_clk;
   tsa_top #(.CONV_CYC(CC)) DUT (.sys_clk(sys_clk), .rstn(rstn), .adc_clk(adc_clk), .adc_valid(adc_valid),
      .adc_result(adc_result), .scl_i(scl), .sda_i(sda_w), .addr_strap(strap), .sda_o(sda_o),
      .sda_oe(sda_oe), .alarm_out(alarm_out));
   tsa_i2c_master M (.clk(sys_clk), .scl(scl), .sda(sda_m), .sda_in(sda_w));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
      checks_done++;
      if (s !== e) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   // Strap set ahead, reset held 3 cycles
   task automatic do_reset(input logic [1:0] s);
      strap = s;
      rstn = 1'b0;
      repeat (3) @(negedge sys_clk);
      rstn = 1'b1;
      repeat (12) @(negedge sys_clk);
   endtask
   // New converter word, then wait n clocks
   task automatic conv(input logic [11:0] t, input int n);
      @(negedge adc_clk);
      adc_result = t;
      adc_valid = 1'b1;
      @(negedge adc_clk);
      adc_valid = 1'b0;
      repeat (n) @(negedge sys_clk);
   endtask
   task automatic t_straps();
      for (int s = 0; s < 4; s++) begin
         do_reset(2'(s));
         M.dev_addr = {ADDR_UPPER, 2'(s)};
         M.probe(a);
         chk("own address ack", 16'h1, {15'h0, a});
         M.dev_addr = {ADDR_UPPER, 2'(s) ^ 2'h1};
         M.probe(a);
         chk("other address ack", 16'h0, {15'h0, a});
      end
      do_reset(2'h0);
      M.dev_addr = {ADDR_UPPER, 2'h0};
   endtask
   task automatic t_reset_vals();
      logic [15:0] e [4];
      e = '{TEMP_RESET, {CFG_RESET, 8'h00}, LOW_RESET, HIGH_RESET};
      for (int p = 0; p < 4; p++) begin
         M.wr(8'(p));
         M.rd(v);
         chk("reset value", e[p], v);
      end
   endtask
   task automatic t_regs();
      M.wr(8'hFF, 2, 16'h12FF);
      M.rd(v);
      chk("high limit", 16'h1280, v);
      M.rd(v);
      chk("pointer kept", 16'h1280, v);
      conv(12'h190, 2 * CC);
      M.wr(8'h00);
      M.rd(v);
      chk("temperature", 16'h1900, v);
      conv(12'hFF8, 2 * CC);
      M.rd(v);
      chk("negative temp", 16'hFF80, v);
      M.wr(8'h01, 1, 16'h0100);
      M.wr(8'h00);
      M.rd(v);
      chk("shutdown temp", TEMP_RESET, v);
      M.wr(8'h01, 1, 16'h0000);
      M.wr(8'h00);
      M.rd(v);
      chk("waking temp", TEMP_RESET, v);
   endtask
   task automatic t_alarm();
      M.wr(8'h03, 2, 16'h1900);
      M.wr(8'h02, 2, 16'h1800);
      M.wr(8'h01, 1, 16'h0C00);
      chk("alarm high idle", 16'h0, al_w);
      conv(12'h1A0, CC - 20);
      chk("alarm one fault", 16'h0, al_w);
      repeat (2 * CC) @(negedge sys_clk);
      chk("alarm set", 16'h1, al_w);
      conv(12'h170, 3 * CC);
      chk("alarm hysteresis", 16'h0, al_w);
      M.wr(8'h01, 1, 16'h0A00);
      conv(12'h1A0, 3 * CC);
      chk("interrupt set", 16'h0, al_w);
      M.rd(v);
      chk("interrupt cleared", 16'h1, al_w);
      repeat (3 * CC) @(negedge sys_clk);
      chk("watch low only", 16'h1, al_w);
      conv(12'h170, 3 * CC);
      chk("low fault", 16'h0, al_w);
      M.wr(8'h01, 1, 16'h0A00);
      chk("write clears", 16'h1, al_w);
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      #780us;
      err_total++;
      report_and_stop();
   end
   initial begin
      t_straps();
      t_reset_vals();
      t_regs();
      t_alarm();
      report_and_stop();
   end
endmodule

// file: logic/tsa_adc_cdc.sv
// Carries converter results from the converter clock into the system clock
`timescale 1ns/10ps
module tsa_adc_cdc
   import tsa_pkg::*;
(
   input wire logic adc_clk, // Converter clock
   input wire logic sys_clk, // System clock
   input wire logic rstn, // Async reset, active low
   input wire logic adc_valid, // Result strobe, adc_clk
   input wire logic [tsa_pkg::ADC_W-1:0] adc_result, // Result word, adc_clk
   output logic [tsa_pkg::ADC_W-1:0] smp_data // Latest result, sys_clk
);
   logic [ADC_W-1:0] hold_reg, hold_next; // Held word, stable across crossing
   logic tgl_reg, tgl_next; // Event toggle
   logic tgl_s; // Toggle after synchroniser
   logic tgl_d_reg, tgl_d_next; // Previous synchronised toggle
   logic [ADC_W-1:0] smp_reg, smp_next; // Copy in system domain

   // Converter side: hold the word and flip the toggle on the same edge
   always_comb begin
      hold_next = hold_reg;
      tgl_next = tgl_reg;
      if (adc_valid) begin
         hold_next = adc_result;
         tgl_next = ~tgl_reg;
      end
   end

   always_ff @(posedge adc_clk or negedge rstn) begin
      if (!rstn) begin
         hold_reg <= '0;
         tgl_reg <= 1'b0;
      end else begin
         hold_reg <= hold_next;
         tgl_reg <= tgl_next;
      end
   end

   tsa_sync #(.W(1)) u_tgl_sync (
      .clk(sys_clk),
      .rstn(rstn),
      .d(tgl_reg),
      .q(tgl_s)
   );

   // System side: word is settled by the time the toggle lands
   always_comb begin
      tgl_d_next = tgl_s;
      smp_next = smp_reg;
      if (tgl_s != tgl_d_reg) begin
         smp_next = hold_reg;
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         tgl_d_reg <= 1'b0;
         smp_reg <= '0;
      end else begin
         tgl_d_reg <= tgl_d_next;
         smp_reg <= smp_next;
      end
   end

   assign smp_data = smp_reg;
endmodule

// file: logic/tsa_pkg.sv
// Shared constants, field layouts and types for the temperature sensor alarm block
package tsa_pkg;
   // Clock and timebase
   localparam int CLK_PERIOD_NS = 8;
   localparam int CONV_TIME_MS = 133;
   localparam int CONV_CYCLES = CONV_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int CONV_CNT_W = 25;
   // Glitch filter: shortest change that passes, rounded down
   localparam int SPIKE_NS = 50;
   localparam int SPIKE_CYCLES = (SPIKE_NS / CLK_PERIOD_NS) < 1 ? 1 : (SPIKE_NS / CLK_PERIOD_NS);
   // Widths
   localparam int SYNC_W = 4;
   localparam int ADC_W = 12;
   // Slave address, upper five bits fixed, low two from the strap
   localparam logic [4:0] ADDR_UPPER = 5'h12;
   // Register select codes
   localparam logic [1:0] PTR_TEMP = 2'h0;
   localparam logic [1:0] PTR_CFG = 2'h1;
   localparam logic [1:0] PTR_LOW = 2'h2;
   localparam logic [1:0] PTR_HIGH = 2'h3;
   // Reset values and masks
   localparam logic [15:0] TEMP_RESET = 16'h8000;
   localparam logic [15:0] TEMP_MASK = 16'hFFF0;
   localparam logic [15:0] LIMIT_MASK = 16'hFF80;
   localparam logic [15:0] LOW_RESET = 16'h4B00;
   localparam logic [15:0] HIGH_RESET = 16'h5000;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] CFG_WR_MASK = 8'h1F;
   // Fault counts per depth code
   localparam logic [2:0] FQ_N0 = 3'h1;
   localparam logic [2:0] FQ_N1 = 3'h2;
   localparam logic [2:0] FQ_N2 = 3'h4;
   localparam logic [2:0] FQ_N3 = 3'h6;

   // Settings register layout
   typedef struct packed {
      logic [2:0] rsvd;      // Reads zero
      logic [1:0] fq_depth;  // Fault count code
      logic polarity;        // 1 = alarm active high
      logic int_mode;        // 1 = interrupt behaviour
      logic shutdown;        // 1 = conversions stopped
   } tsa_cfg_s;

   // Pins crossing into the system clock
   typedef struct packed {
      logic scl;
      logic sda;
      logic [1:0] strap;
   } tsa_pins_s;

   // Serial slave states
   typedef enum {
      ST_IDLE,
      ST_ADDR,
      ST_AACK,
      ST_WRITE,
      ST_WACK,
      ST_READ,
      ST_RACK
   } tsa_state_e;
endpackage

// file: logic/tsa_sync.sv
// Two flip-flop synchroniser for levels entering the system clock
`timescale 1ns/10ps
module tsa_sync #(
   parameter int W = 1 // Number of bits
) (
   input wire logic clk, // Destination clock
   input wire logic rstn, // Async reset, active low
   input wire logic [W-1:0] d, // Asynchronous levels
   output logic [W-1:0] q // Synchronised levels
);
   logic [W-1:0] meta_reg; // First stage, read only by second
   logic [W-1:0] q_reg; // Second stage

   // Plain two-stage chain, no logic between
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_reg <= '0;
         q_reg <= '0;
      end else begin
         meta_reg <= d;
         q_reg <= meta_reg;
      end
   end

   assign q = q_reg;
endmodule

// file: logic/tsa_top.sv
// Temperature monitor: serial slave, registers, conversion timebase and alarm
// How it works
// [R1] Convert continuously, store each finished result
// [R2] Temperature reads 8000H until first result
// [R3] Shutdown forces 8000H, stops conversions only
// [R4] Settings bit 0 selects shutdown
// [R5] Slave only: byte/word reads and writes
// [R6] Address 100 10xx, low bits from strap
// [R7] Pointer bits 1:0 select target register
// [R8] Pointer bits 7:2 ignored, read zero
// [R9] Temperature 16-bit read-only, left-justified, zero-padded
// [R10] Two's complement, bit 15 is sign
// [R11] Temperature read aborts current conversion
// [R12] Conversions restart after stop condition
// [R13] Master writes zeros to settings bits 7:5
// [R14] Settings bit 1 selects interrupt behaviour
// [R15] Settings bit 2 selects alarm polarity
// [R16] Settings bits 4:3 set fault count
// [R17] Alarm asserts above high limit after count
// [R18] Comparator clears below low limit after count
// [R19] Interrupt alarm clears on any read
// [R20] Limits keep bits 15:7, rest zero
// [R21] Master writes pointer first in transaction
// [R22] Fault counter clears on reset, shutdown, writes
// [R23] Counter clear drops alarm, rearms high watch
// [R24] In-limit result with no alarm clears counter
// [R25] Interrupt mode alternates high and low watch
// [R26] Pointer persists between transactions
// [R27] Bus lines synchronised and filtered first
`timescale 1ns/10ps
module tsa_top #(
   parameter int CONV_CYC = tsa_pkg::CONV_CYCLES // Cycles per conversion
) (
   input wire logic sys_clk, // System clock, 125 MHz
   input wire logic rstn, // Async reset, active low
   input wire logic adc_clk, // Converter clock
   input wire logic adc_valid, // Converter result strobe
   input wire logic [tsa_pkg::ADC_W-1:0] adc_result, // Converter result
   input wire logic scl_i, // Bus clock level
   input wire logic sda_i, // Bus data level
   input wire logic [1:0] addr_strap, // Address strap level
   output logic sda_o, // Bus data drive value
   output logic sda_oe, // Bus data pulls low when high
   output logic alarm_out // Temperature alarm
);
   import tsa_pkg::*;

   // Register word as seen by a read
   function automatic logic [15:0] reg_word(input logic [1:0] sel, input logic [15:0] t,
                                            input tsa_cfg_s c, input logic [15:0] lo,
                                            input logic [15:0] hi);
      logic [15:0] w;
      case (sel)
         PTR_CFG: w = {c, 8'h00};
         PTR_LOW: w = lo;
         PTR_HIGH: w = hi;
         default: w = t;
      endcase
      return w;
   endfunction

   // Fault count for a depth code
   function automatic logic [2:0] fq_limit(input logic [1:0] code);
      logic [2:0] n;
      case (code)
         2'h1: n = FQ_N1;
         2'h2: n = FQ_N2;
         2'h3: n = FQ_N3;
         default: n = FQ_N0;
      endcase
      return n;
   endfunction

   tsa_pins_s pins_s; // Pins after synchroniser
   logic [ADC_W-1:0] smp_data; // Latest converter word
   logic [1:0] line_raw; // Synced scl, sda
   logic [1:0] line_flt; // Filtered scl, sda

   tsa_sync #(.W(SYNC_W)) u_pin_sync (
      .clk(sys_clk),
      .rstn(rstn),
      .d({scl_i, sda_i, addr_strap}),
      .q(pins_s)
   ); // [R27]

   tsa_adc_cdc u_adc_cdc (
      .adc_clk(adc_clk),
      .sys_clk(sys_clk),
      .rstn(rstn),
      .adc_valid(adc_valid),
      .adc_result(adc_result),
      .smp_data(smp_data)
   );

   assign line_raw = {pins_s.scl, pins_s.sda};

   // Spike filter per line: a change must hold SPIKE_CYCLES cycles
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_flt
         logic [2:0] cnt_reg, cnt_next; // Stability count
         logic val_reg, val_next; // Filtered level
         always_comb begin
            cnt_next = 3'h0;
            val_next = val_reg;
            if (line_raw[gi] != val_reg) begin
               if (cnt_reg == 3'(SPIKE_CYCLES - 1)) begin
                  val_next = line_raw[gi]; // [R27]
               end else begin
                  cnt_next = cnt_reg + 3'h1;
               end
            end
         end
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               cnt_reg <= 3'h0;
               val_reg <= 1'b1;
            end else begin
               cnt_reg <= cnt_next;
               val_reg <= val_next;
            end
         end
         assign line_flt[gi] = val_reg;
      end
   endgenerate

   // Bus line history and strap capture
   logic scl_d_reg, sda_d_reg; // Previous filtered levels
   logic [1:0] strap_cnt_reg, strap_cnt_next; // Edges since release, strap frozen at 3
   logic [1:0] addr_low_reg, addr_low_next; // Captured strap code
   logic scl_rise, scl_fall, bus_start, bus_stop; // Line events

   assign scl_rise = line_flt[1] & ~scl_d_reg;
   assign scl_fall = ~line_flt[1] & scl_d_reg;
   assign bus_start = line_flt[1] & scl_d_reg & sda_d_reg & ~line_flt[0];
   assign bus_stop = line_flt[1] & scl_d_reg & ~sda_d_reg & line_flt[0];

   // Strap followed until the reset-cleared synchroniser has refilled, then frozen
   always_comb begin
      strap_cnt_next = strap_cnt_reg;
      addr_low_next = addr_low_reg;
      if (strap_cnt_reg != 2'h3) begin
         strap_cnt_next = strap_cnt_reg + 2'h1;
         addr_low_next = pins_s.strap; // [R6]
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         strap_cnt_reg <= 2'h0;
         addr_low_reg <= 2'h0;
      end else begin
         scl_d_reg <= line_flt[1];
         sda_d_reg <= line_flt[0];
         strap_cnt_reg <= strap_cnt_next;
         addr_low_reg <= addr_low_next;
      end
   end

   // Serial slave and register file state
   tsa_state_e st_reg, st_next; // Slave state
   logic [3:0] bit_reg, bit_next; // Bits seen in this byte
   logic [7:0] sh_reg, sh_next; // Receive shifter
   logic [15:0] tx_reg, tx_next; // Transmit shifter, MSB out first
   logic rw_reg, rw_next; // 1 = read transaction
   logic nack_reg, nack_next; // Master refused more data
   logic [1:0] idx_reg, idx_next; // Byte index after address
   logic [1:0] ptr_reg, ptr_next; // Register selector
   tsa_cfg_s cfg_reg, cfg_next; // Settings
   logic [15:0] low_reg, low_next; // Low limit
   logic [15:0] high_reg, high_next; // High limit
   logic [7:0] msb_reg, msb_next; // First byte of a word write
   logic oe_reg, oe_next; // Data pull-down
   logic hold_reg, hold_next; // Conversion held after abort
   logic ev_qclr; // Limit or settings write
   logic ev_rd; // Read addressed
   logic [15:0] temp_reg, temp_next; // Temperature register

   // Byte-level slave: sample on rise, drive on fall
   always_comb begin
      st_next = st_reg;
      bit_next = bit_reg;
      sh_next = sh_reg;
      tx_next = tx_reg;
      rw_next = rw_reg;
      nack_next = nack_reg;
      idx_next = idx_reg;
      ptr_next = ptr_reg;
      cfg_next = cfg_reg;
      low_next = low_reg;
      high_next = high_reg;
      msb_next = msb_reg;
      oe_next = oe_reg;
      hold_next = hold_reg;
      ev_qclr = 1'b0;
      ev_rd = 1'b0;
      if (bus_stop) begin
         st_next = ST_IDLE;
         oe_next = 1'b0;
         hold_next = 1'b0; // [R12]
      end else if (bus_start) begin
         st_next = ST_ADDR;
         bit_next = 4'h0;
         idx_next = 2'h0;
         oe_next = 1'b0;
      end else if (scl_rise) begin
         case (st_reg)
            ST_ADDR, ST_WRITE: begin
               sh_next = {sh_reg[6:0], line_flt[0]};
               bit_next = bit_reg + 4'h1;
            end
            ST_READ: bit_next = bit_reg + 4'h1;
            ST_RACK: nack_next = line_flt[0];
            default: ;
         endcase
      end else if (scl_fall) begin
         case (st_reg)
            ST_ADDR: begin
               if (bit_reg == 4'h8) begin
                  if (sh_reg[7:1] == {ADDR_UPPER, addr_low_reg}) begin // [R6]
                     oe_next = 1'b1;
                     rw_next = sh_reg[0];
                     st_next = ST_AACK;
                     if (sh_reg[0]) begin
                        // Read uses the pointer left from earlier
                        tx_next = reg_word(ptr_reg, temp_reg, cfg_reg, low_reg, high_reg); // [R26]
                        ev_rd = 1'b1; // [R19]
                        if (ptr_reg == PTR_TEMP) begin
                           hold_next = 1'b1; // [R11]
                        end
                     end
                  end else begin
                     st_next = ST_IDLE; // Not ours: wait for next start
                  end
               end
            end
            ST_AACK: begin
               bit_next = 4'h0;
               if (rw_reg) begin
                  st_next = ST_READ;
                  oe_next = ~tx_reg[15];
               end else begin
                  st_next = ST_WRITE;
                  oe_next = 1'b0;
               end
            end
            ST_WRITE: begin
               if (bit_reg == 4'h8) begin
                  oe_next = 1'b1;
                  st_next = ST_WACK;
                  if (idx_reg != 2'h3) begin
                     idx_next = idx_reg + 2'h1;
                  end
                  case (idx_reg)
                     2'h0: ptr_next = sh_reg[1:0]; // [R7] [R8] [R21]
                     2'h1: begin
                        if (ptr_reg == PTR_CFG) begin
                           cfg_next = tsa_cfg_s'(sh_reg & CFG_WR_MASK); // [R4] [R13]
                           ev_qclr = 1'b1; // [R22]
                        end
                        msb_next = sh_reg;
                     end
                     2'h2: begin
                        if (ptr_reg == PTR_LOW) begin
                           low_next = {msb_reg, sh_reg} & LIMIT_MASK; // [R20]
                           ev_qclr = 1'b1; // [R22]
                        end else if (ptr_reg == PTR_HIGH) begin
                           high_next = {msb_reg, sh_reg} & LIMIT_MASK; // [R20]
                           ev_qclr = 1'b1; // [R22]
                        end
                     end
                     default: ; // Extra bytes acknowledged, dropped
                  endcase
               end
            end
            ST_WACK: begin
               oe_next = 1'b0;
               bit_next = 4'h0;
               st_next = ST_WRITE;
            end
            ST_READ: begin
               tx_next = {tx_reg[14:0], 1'b0};
               if (bit_reg == 4'h8) begin
                  oe_next = 1'b0; // Release for master ack
                  st_next = ST_RACK;
               end else begin
                  oe_next = ~tx_reg[14];
               end
            end
            ST_RACK: begin
               if (nack_reg) begin
                  st_next = ST_IDLE;
               end else begin
                  st_next = ST_READ; // [R5]
                  bit_next = 4'h0;
                  oe_next = ~tx_reg[15];
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= ST_IDLE;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         tx_reg <= 16'h0000;
         rw_reg <= 1'b0;
         nack_reg <= 1'b0;
         idx_reg <= 2'h0;
         ptr_reg <= PTR_TEMP;
         cfg_reg <= tsa_cfg_s'(CFG_RESET);
         low_reg <= LOW_RESET;
         high_reg <= HIGH_RESET;
         msb_reg <= 8'h00;
         oe_reg <= 1'b0;
         hold_reg <= 1'b0;
      end else begin
         st_reg <= st_next;
         bit_reg <= bit_next;
         sh_reg <= sh_next;
         tx_reg <= tx_next;
         rw_reg <= rw_next;
         nack_reg <= nack_next;
         idx_reg <= idx_next;
         ptr_reg <= ptr_next;
         cfg_reg <= cfg_next;
         low_reg <= low_next;
         high_reg <= high_next;
         msb_reg <= msb_next;
         oe_reg <= oe_next;
         hold_reg <= hold_next;
      end
   end

   // Conversion timebase, temperature register and alarm state
   logic [CONV_CNT_W-1:0] conv_reg, conv_next; // Cycles into conversion
   logic [2:0] fq_reg, fq_next; // Consecutive faults
   logic alarm_reg, alarm_next; // Alarm asserted, polarity-free
   logic watch_low_reg, watch_low_next; // Interrupt mode watches low limit
   logic out_reg, out_next; // Pin level
   logic conv_done; // Conversion finished this cycle
   logic fault; // Result out of the watched limit
   logic [15:0] temp_new; // Masked new result

   // Faults count only at conversion ends; clears win over counting
   always_comb begin
      conv_next = conv_reg;
      temp_next = temp_reg;
      fq_next = fq_reg;
      alarm_next = alarm_reg;
      watch_low_next = watch_low_reg;
      conv_done = 1'b0;
      fault = 1'b0;
      temp_new = {smp_data, 4'h0} & TEMP_MASK; // [R9] [R10]
      if (cfg_reg.shutdown || hold_reg) begin
         conv_next = '0; // [R3] [R11]
      end else if (conv_reg == CONV_CNT_W'(CONV_CYC - 1)) begin
         conv_next = '0;
         conv_done = 1'b1; // [R1]
      end else begin
         conv_next = conv_reg + CONV_CNT_W'(1);
      end
      if (cfg_reg.shutdown) begin
         temp_next = TEMP_RESET; // [R3]
      end else if (conv_done) begin
         temp_next = temp_new; // [R1] [R2]
      end
      if (ev_qclr || cfg_reg.shutdown) begin
         fq_next = 3'h0; // [R22]
         alarm_next = 1'b0; // [R23]
         watch_low_next = 1'b0; // [R23]
      end else begin
         if (ev_rd && cfg_reg.int_mode && alarm_reg) begin
            alarm_next = 1'b0; // [R19]
            watch_low_next = ~watch_low_reg; // [R25]
            fq_next = 3'h0;
         end
         if (conv_done) begin
            if (cfg_reg.int_mode) begin // [R14]
               if (watch_low_next) begin
                  fault = $signed(temp_new) < $signed(low_reg); // [R25]
               end else begin
                  fault = $signed(temp_new) > $signed(high_reg); // [R17]
               end
            end else if (alarm_next) begin
               fault = $signed(temp_new) < $signed(low_reg); // [R18]
            end else begin
               fault = $signed(temp_new) > $signed(high_reg); // [R17]
            end
            // Interrupt alarm latches until read; no counting meanwhile
            if (!(cfg_reg.int_mode && alarm_next)) begin
               if (!fault) begin
                  fq_next = 3'h0; // [R24]
               end else if (fq_next + 3'h1 == fq_limit(cfg_reg.fq_depth)) begin // [R16]
                  fq_next = 3'h0;
                  alarm_next = ~alarm_next; // [R17] [R18]
               end else begin
                  fq_next = fq_next + 3'h1;
               end
            end
         end
      end
      out_next = cfg_reg.polarity ? alarm_next : ~alarm_next; // [R15]
   end

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         conv_reg <= '0;
         temp_reg <= TEMP_RESET; // [R2]
         fq_reg <= 3'h0; // [R22]
         alarm_reg <= 1'b0;
         watch_low_reg <= 1'b0;
         out_reg <= 1'b1;
      end else begin
         conv_reg <= conv_next;
         temp_reg <= temp_next;
         fq_reg <= fq_next;
         alarm_reg <= alarm_next;
         watch_low_reg <= watch_low_next;
         out_reg <= out_next;
      end
   end

   // Open-drain data: drive value is always low
   logic sda_o_reg; // Constant drive value
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         sda_o_reg <= 1'b0;
      end else begin
         sda_o_reg <= 1'b0;
      end
   end

   assign sda_o = sda_o_reg;
   assign sda_oe = oe_reg;
   assign alarm_out = out_reg;
endmodule
